// *** common/ufm_pkg.sv ***
// ufm_pkg: shared constants for the 7/8/9-bit frame uart pair.
// assumes a single 100 MHz system clock on both ends.
package ufm_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // frame mode select codes
  localparam logic [1:0] MODE_SYNC  = 2'h0;
  localparam logic [1:0] MODE_7BIT  = 2'h1;
  localparam logic [1:0] MODE_8BIT  = 2'h2;
  localparam logic [1:0] MODE_9BIT  = 2'h3;

  // control register field positions
  localparam int MC0_MODE_LSB  = 0;
  localparam int MC0_WAKE_BIT  = 4;
  localparam int MC0_RXEN_BIT  = 5;
  localparam int MC0_TX9_BIT   = 7;
  localparam int SCR_EVEN_BIT  = 5;
  localparam int SCR_PE_BIT    = 6;
  localparam int SCR_RX9_BIT   = 7;
  localparam int MC2_STOP_BIT  = 1;

  // reset values
  localparam logic [7:0] MC0_RESET  = 8'h00;
  localparam logic [7:0] SCR_RESET  = 8'h00;
  localparam logic [7:0] MC2_RESET  = 8'h00;

  // timing
  localparam int CLK_HZ        = 100_000_000;
  localparam int BAUD_DEFAULT  = 115_200;
  localparam int BIT_CYCLES    = CLK_HZ / BAUD_DEFAULT;
  localparam int CNT_W         = 16;
  localparam int SHIFT_W       = 12;

endpackage

// *** common/ufm_link_if.sv ***
// ufm_link_if: the shared serial line between the channel and its peer.
// assumes point-to-point crossed lines; no wired level is resolved here.
`timescale 1ns/1ns
interface ufm_link_if;
  logic dev_txd;
  logic peer_txd;
  logic dev_rxd;
  logic peer_rxd;

  // crossed lines: each end's transmit is the other's receive
  assign dev_rxd  = peer_txd;
  assign peer_rxd = dev_txd;

  modport device (output dev_txd, input dev_rxd);
  modport peer (output peer_txd, input peer_rxd);
endinterface

// *** verilog/ufm_channel.sv ***
// ufm_channel: asynchronous channel with 7/8/9-bit frames and wake-up filter.
// assumes config fields come in as synchronous levels; link is ufm_link_if.
`timescale 1ns/1ns
module ufm_channel #(
  parameter int BIT_CYCLES = ufm_pkg::BIT_CYCLES
) (
  // clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       rst_i,
  // mode control 0 / serial control / mode control 2 fields
  input  wire logic [1:0] frame_mode_select_i,
  input  wire logic       wake_filter_enable_i,
  input  wire logic       rx_enable_i,
  input  wire logic       tx_ninth_bit_i,
  input  wire logic       parity_enable_i,
  input  wire logic       parity_even_i,
  input  wire logic       stop_length_select_i,
  // data buffer write
  input  wire logic       tx_write_i,
  input  wire logic [7:0] tx_data_i,
  output logic            tx_busy_o,
  // data buffer read side
  output logic [7:0]      rx_data_o,
  output logic            rx_ninth_bit_o,
  output logic            rx_parity_error_o,
  output logic            rx_frame_error_o,
  output logic            receive_interrupt_o,
  // serial line
  ufm_link_if.device      link
);

  typedef enum logic [1:0] {ST_IDLE, ST_SHIFT} ufm_tx_state_t;
  typedef enum logic [1:0] {RS_IDLE, RS_START, RS_DATA, RS_STOP} ufm_rx_state_t;

  typedef struct packed {
    ufm_tx_state_t                    tx_st;
    logic [ufm_pkg::CNT_W-1:0]        tx_cnt;
    logic [ufm_pkg::SHIFT_W-1:0]      tx_sh;
    logic [3:0]                       tx_left;
    logic                             txd;
    ufm_rx_state_t                    rx_st;
    logic [ufm_pkg::CNT_W-1:0]        rx_cnt;
    logic [3:0]                       rx_left;
    logic [9:0]                       rx_sh;
    logic [1:0]                       rx_mode;
    logic                             rx_pe;
    logic                             rx_even;
    logic [7:0]                       rx_data;
    logic                             rx_nine;
    logic                             perr;
    logic                             ferr;
    logic                             irq;
  } ufm_chan_state_t;

  localparam logic [ufm_pkg::CNT_W-1:0] BIT_LAST  = ufm_pkg::CNT_W'(BIT_CYCLES - 1);
  localparam logic [ufm_pkg::CNT_W-1:0] HALF_LAST = ufm_pkg::CNT_W'(BIT_CYCLES / 2 - 1);

  ufm_chan_state_t s_q;
  ufm_chan_state_t s_d;

  //////////////////////////////////////////////////////////////////////////////
  // frame width helpers
  function automatic logic [3:0] data_bits(input logic [1:0] m);
    data_bits = (m == ufm_pkg::MODE_7BIT) ? 4'h7 : 4'h8;
  endfunction

  function automatic logic has_extra(input logic [1:0] m, input logic pe);
    // 9-bit mode ignores parity enable, so a stray set cannot add a tenth bit
    has_extra = (m == ufm_pkg::MODE_9BIT) | pe;
  endfunction

  logic [3:0] tx_nbits;
  logic       tx_extra;
  logic       tx_par;
  logic [7:0] tx_masked;
  logic [3:0] rx_nbits;
  logic       rx_extra;
  logic [7:0] rx_byte;
  logic       rx_xbit;
  logic       rx_calc;
  logic       rx_accept;

  always_comb begin
    tx_nbits  = data_bits(frame_mode_select_i);
    tx_extra  = has_extra(frame_mode_select_i, parity_enable_i);
    tx_masked = (frame_mode_select_i == ufm_pkg::MODE_7BIT) ? {1'b0, tx_data_i[6:0]} : tx_data_i;
    tx_par    = (^tx_masked) ^ ~parity_even_i;
    rx_nbits  = data_bits(s_q.rx_mode);
    rx_extra  = has_extra(s_q.rx_mode, s_q.rx_pe);
    // received bits arrive lsb first into the top of rx_sh
    rx_byte   = 8'h00;
    rx_xbit   = 1'b0;
    case ({s_q.rx_mode == ufm_pkg::MODE_7BIT, rx_extra})
      2'b11: begin
        rx_byte = {1'b0, s_q.rx_sh[8:2]};
        rx_xbit = s_q.rx_sh[9];
      end
      2'b10: begin
        rx_byte = {1'b0, s_q.rx_sh[9:3]};
      end
      2'b01: begin
        rx_byte = s_q.rx_sh[8:1];
        rx_xbit = s_q.rx_sh[9];
      end
      default: begin
        rx_byte = s_q.rx_sh[9:2];
      end
    endcase
    rx_calc   = (^rx_byte) ^ ~s_q.rx_even;
    rx_accept = !(s_q.rx_mode == ufm_pkg::MODE_9BIT && wake_filter_enable_i
                  && !rx_xbit);
  end

  //////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    s_d     = s_q;
    s_d.irq = 1'b0;
    // transmitter
    case (s_q.tx_st)
      ST_IDLE: begin
        s_d.txd = 1'b1;
        if (tx_write_i && frame_mode_select_i != ufm_pkg::MODE_SYNC) begin
          // start, data lsb first, extra bit, then stops, all in one shift word
          // 7-bit frames put a stop in bit 8 unless the extra bit claims it
          s_d.tx_sh = {3'b111, tx_masked[7] | (frame_mode_select_i == ufm_pkg::MODE_7BIT),
                       tx_masked[6:0], 1'b0};
          if (tx_extra) begin
            s_d.tx_sh[tx_nbits + 4'h1] = (frame_mode_select_i == ufm_pkg::MODE_9BIT)
                                         ? tx_ninth_bit_i : tx_par;
          end
          s_d.tx_left = tx_nbits + {3'h0, tx_extra} + 4'h2
                        + {3'h0, stop_length_select_i};
          s_d.tx_cnt  = '0;
          s_d.tx_st   = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        s_d.txd = s_q.tx_sh[0];
        if (s_q.tx_cnt == BIT_LAST) begin
          s_d.tx_cnt  = '0;
          s_d.tx_sh   = {1'b1, s_q.tx_sh[ufm_pkg::SHIFT_W-1:1]};
          s_d.tx_left = s_q.tx_left - 4'h1;
          if (s_q.tx_left == 4'h1) begin
            s_d.tx_st = ST_IDLE;
          end
        end else begin
          s_d.tx_cnt = s_q.tx_cnt + 1'b1;
        end
      end
      default: s_d.tx_st = ST_IDLE;
    endcase
    // receiver
    case (s_q.rx_st)
      RS_IDLE: begin
        s_d.rx_cnt = '0;
        if (rx_enable_i && !link.dev_rxd
            && frame_mode_select_i != ufm_pkg::MODE_SYNC) begin
          s_d.rx_mode = frame_mode_select_i;
          s_d.rx_pe   = parity_enable_i;
          s_d.rx_even = parity_even_i;
          s_d.rx_st   = RS_START;
        end
      end
      RS_START: begin
        if (s_q.rx_cnt == HALF_LAST) begin
          s_d.rx_cnt  = '0;
          // glitch shorter than half a bit is dropped
          s_d.rx_st   = link.dev_rxd ? RS_IDLE : RS_DATA;
          s_d.rx_left = rx_nbits + {3'h0, rx_extra};
          s_d.rx_sh   = '0;
        end else begin
          s_d.rx_cnt = s_q.rx_cnt + 1'b1;
        end
      end
      RS_DATA: begin
        if (s_q.rx_cnt == BIT_LAST) begin
          s_d.rx_cnt  = '0;
          s_d.rx_sh   = {link.dev_rxd, s_q.rx_sh[9:1]};
          s_d.rx_left = s_q.rx_left - 4'h1;
          if (s_q.rx_left == 4'h1) begin
            s_d.rx_st = RS_STOP;
          end
        end else begin
          s_d.rx_cnt = s_q.rx_cnt + 1'b1;
        end
      end
      RS_STOP: begin
        if (s_q.rx_cnt == BIT_LAST) begin
          s_d.rx_st = RS_IDLE;
          if (rx_accept) begin
            s_d.rx_data = rx_byte;
            s_d.rx_nine = (s_q.rx_mode == ufm_pkg::MODE_9BIT) ? rx_xbit : 1'b0;
            s_d.perr    = (s_q.rx_mode != ufm_pkg::MODE_9BIT) && s_q.rx_pe
                          && (rx_xbit != rx_calc);
            s_d.ferr    = !link.dev_rxd;
            s_d.irq     = 1'b1;
          end
        end else begin
          s_d.rx_cnt = s_q.rx_cnt + 1'b1;
        end
      end
      default: s_d.rx_st = RS_IDLE;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      s_q         <= '0;
      s_q.tx_st   <= ST_IDLE;
      s_q.rx_st   <= RS_IDLE;
      s_q.tx_sh   <= '1;
      s_q.txd     <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign link.dev_txd        = s_q.txd;
  assign tx_busy_o           = s_q.tx_st != ST_IDLE;
  assign rx_data_o           = s_q.rx_data;
  assign rx_ninth_bit_o      = s_q.rx_nine;
  assign rx_parity_error_o   = s_q.perr;
  assign rx_frame_error_o    = s_q.ferr;
  assign receive_interrupt_o = s_q.irq;

endmodule

// *** verilog/ufm_peer.sv ***
// ufm_peer: far-end multi-drop master, sends 9-bit frames only, 1 stop bit.
// assumes the link interface crosses lines to the channel under test.
`timescale 1ns/1ns
module ufm_peer #(
  parameter int BIT_CYCLES = ufm_pkg::BIT_CYCLES
) (
  // clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       rst_i,
  // send request
  input  wire logic       send_addr_i,
  input  wire logic       send_data_i,
  input  wire logic [7:0] byte_i,
  output logic            busy_o,
  // reply capture
  output logic [7:0]      reply_o,
  output logic            reply_valid_o,
  // serial line
  ufm_link_if.peer        link
);

  typedef enum logic [1:0] {PS_IDLE, PS_TX, PS_RXS, PS_RX} ufm_peer_state_t;

  typedef struct packed {
    ufm_peer_state_t                  st;
    logic [ufm_pkg::CNT_W-1:0]        cnt;
    logic [10:0]                      sh;
    logic [3:0]                       left;
    logic                             txd;
    logic [7:0]                       reply;
    logic                             rv;
  } ufm_peer_s_t;

  localparam logic [ufm_pkg::CNT_W-1:0] BIT_LAST  = ufm_pkg::CNT_W'(BIT_CYCLES - 1);
  localparam logic [ufm_pkg::CNT_W-1:0] HALF_LAST = ufm_pkg::CNT_W'(BIT_CYCLES / 2 - 1);

  ufm_peer_s_t s_q;
  ufm_peer_s_t s_d;

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_d    = s_q;
    s_d.rv = 1'b0;
    case (s_q.st)
      PS_IDLE: begin
        s_d.txd = 1'b1;
        s_d.cnt = '0;
        if (send_addr_i || send_data_i) begin
          // address frames carry ninth bit one, data frames zero
          s_d.sh   = {1'b1, send_addr_i, byte_i, 1'b0};
          s_d.left = 4'hb;
          s_d.st   = PS_TX;
        end else if (!link.peer_rxd) begin
          s_d.st = PS_RXS;
        end
      end
      PS_TX: begin
        s_d.txd = s_q.sh[0];
        if (s_q.cnt == BIT_LAST) begin
          s_d.cnt  = '0;
          s_d.sh   = {1'b1, s_q.sh[10:1]};
          s_d.left = s_q.left - 4'h1;
          if (s_q.left == 4'h1) begin
            s_d.st = PS_IDLE;
          end
        end else begin
          s_d.cnt = s_q.cnt + 1'b1;
        end
      end
      PS_RXS: begin
        if (s_q.cnt == HALF_LAST) begin
          s_d.cnt  = '0;
          s_d.left = 4'h8;
          s_d.st   = link.peer_rxd ? PS_IDLE : PS_RX;
        end else begin
          s_d.cnt = s_q.cnt + 1'b1;
        end
      end
      PS_RX: begin
        if (s_q.cnt == BIT_LAST) begin
          s_d.cnt   = '0;
          s_d.reply = {link.peer_rxd, s_q.reply[7:1]};
          s_d.left  = s_q.left - 4'h1;
          if (s_q.left == 4'h1) begin
            // reply assumed 8-bit, no parity; stop bit not checked
            s_d.rv = 1'b1;
            s_d.st = PS_IDLE;
          end
        end else begin
          s_d.cnt = s_q.cnt + 1'b1;
        end
      end
      default: s_d.st = PS_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      s_q     <= '0;
      s_q.st  <= PS_IDLE;
      s_q.txd <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign link.peer_txd = s_q.txd;
  assign busy_o        = s_q.st != PS_IDLE;
  assign reply_o       = s_q.reply;
  assign reply_valid_o = s_q.rv;

endmodule

// *** sim/ufm_monitor.sv ***
// ufm_monitor: port and line checks on the channel that faces the peer.
// assumes config levels stay steady for a whole frame.
`timescale 1ns/1ns
module ufm_monitor #(
  parameter int BIT_CYCLES = 8
) (
  // clock and reset
  input wire logic       sys_clk_i,
  input wire logic       rst_i,
  // channel config and user side
  input wire logic [1:0] frame_mode_select_i,
  input wire logic       parity_enable_i,
  input wire logic       stop_length_select_i,
  input wire logic       wake_filter_enable_i,
  input wire logic       tx_write_i,
  input wire logic [7:0] tx_data_i,
  input wire logic       tx_ninth_bit_i,
  input wire logic       tx_busy_o,
  input wire logic       rx_ninth_bit_o,
  input wire logic       receive_interrupt_o,
  // serial line
  input wire logic       dev_txd
);
  // slack of two cycles around the busy edge
  localparam int L7   = 9 * BIT_CYCLES - 2;
  localparam int L9   = 12 * BIT_CYCLES - 2;
  localparam int MID9 = 9 * BIT_CYCLES + 4;
  localparam int MID0 = BIT_CYCLES + 5;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////////////////////
  property p_idle_high; !tx_busy_o |-> dev_txd; endproperty
  a_idle_high: assert property (p_idle_high) else $error("line not idle high");
  property p_start;
    tx_write_i && !tx_busy_o && frame_mode_select_i != ufm_pkg::MODE_SYNC
      |-> ##[1:2] (!dev_txd && tx_busy_o);
  endproperty
  a_start: assert property (p_start) else $error("no start bit");
  // the line drops one cycle after busy rises
  property p_start_len; $rose(tx_busy_o) |=> (!dev_txd)[*8]; endproperty
  a_start_len: assert property (p_start_len) else $error("start bit short");
  property p_len7;
    $rose(tx_busy_o) && frame_mode_select_i == ufm_pkg::MODE_7BIT && !parity_enable_i
      && !stop_length_select_i |-> ##L7 tx_busy_o ##[1:3] !tx_busy_o;
  endproperty
  a_len7: assert property (p_len7) else $error("7-bit frame length");
  property p_len9;
    $rose(tx_busy_o) && frame_mode_select_i == ufm_pkg::MODE_9BIT && stop_length_select_i
      |-> ##L9 tx_busy_o ##[1:3] !tx_busy_o;
  endproperty
  a_len9: assert property (p_len9) else $error("9-bit two stop length");
  property p_ninth;
    tx_write_i && !tx_busy_o && frame_mode_select_i == ufm_pkg::MODE_9BIT
      |-> ##MID9 dev_txd == $past(tx_ninth_bit_i, MID9);
  endproperty
  a_ninth: assert property (p_ninth) else $error("ninth bit on line");
  property p_lsb;
    tx_write_i && !tx_busy_o && frame_mode_select_i != ufm_pkg::MODE_SYNC
      |-> ##MID0 dev_txd == $past(tx_data_i[0], MID0);
  endproperty
  a_lsb: assert property (p_lsb) else $error("first data bit");
  property p_irq_wake;
    receive_interrupt_o && wake_filter_enable_i
      && frame_mode_select_i == ufm_pkg::MODE_9BIT |-> rx_ninth_bit_o;
  endproperty
  a_irq_wake: assert property (p_irq_wake) else $error("irq with ninth zero");
  property p_refuse;
    tx_write_i && !tx_busy_o && frame_mode_select_i == ufm_pkg::MODE_SYNC
      |=> (!tx_busy_o)[*2];
  endproperty
  a_refuse: assert property (p_refuse) else $error("frame in mode 00");
endmodule

// *** sim/test_uart_7_8_9_bit_frame_modes.sv ***
// test_uart_7_8_9_bit_frame_modes: channel against the peer, and a second
// channel whose line the bench drives bit by bit; all stimulus at negedge.
`timescale 1ns/1ns
module test_uart_7_8_9_bit_frame_modes;
  localparam int B = 8;
  logic       sys_clk_i, rst_i, wake, pe, even, stop2, wr, tx9, s_addr, s_data;
  logic [1:0] mode;
  logic [7:0] txb, pbyte, rx_data, rx2_data, reply;
  logic       busy, nine, irq, pbusy, rv, nine2, perr2, ferr2, irq2;
  int         err_count = 0, checks = 0, cyc = 0, irq_n = 0, irq2_n = 0, rv_n = 0;
  ufm_link_if u_ufm_link_if ();
  ufm_link_if u_ufm_link_if_2 ();
  ufm_channel #(.BIT_CYCLES(B)) u_ufm_channel (.sys_clk_i, .rst_i,
    .frame_mode_select_i(mode), .wake_filter_enable_i(wake), .rx_enable_i(1'b1),
    .tx_ninth_bit_i(tx9), .parity_enable_i(pe), .parity_even_i(even),
    .stop_length_select_i(stop2), .tx_write_i(wr), .tx_data_i(txb), .tx_busy_o(busy),
    .rx_data_o(rx_data), .rx_ninth_bit_o(nine), .rx_parity_error_o(),
    .rx_frame_error_o(), .receive_interrupt_o(irq), .link(u_ufm_link_if.device));
  ufm_channel #(.BIT_CYCLES(B)) u_ufm_channel_2 (.sys_clk_i, .rst_i,
    .frame_mode_select_i(mode), .wake_filter_enable_i(wake), .rx_enable_i(1'b1),
    .tx_ninth_bit_i(tx9), .parity_enable_i(pe), .parity_even_i(even),
    .stop_length_select_i(stop2), .tx_write_i(1'b0), .tx_data_i(txb), .tx_busy_o(),
    .rx_data_o(rx2_data), .rx_ninth_bit_o(nine2), .rx_parity_error_o(perr2),
    .rx_frame_error_o(ferr2), .receive_interrupt_o(irq2), .link(u_ufm_link_if_2.device));
  ufm_peer #(.BIT_CYCLES(B)) u_ufm_peer (.sys_clk_i, .rst_i, .send_addr_i(s_addr),
    .send_data_i(s_data), .byte_i(pbyte), .busy_o(pbusy), .reply_o(reply),
    .reply_valid_o(rv), .link(u_ufm_link_if.peer));
  ufm_monitor #(.BIT_CYCLES(B)) u_ufm_monitor (.sys_clk_i, .rst_i,
    .frame_mode_select_i(mode), .parity_enable_i(pe), .stop_length_select_i(stop2),
    .wake_filter_enable_i(wake), .tx_write_i(wr), .tx_data_i(txb), .tx_ninth_bit_i(tx9),
    .tx_busy_o(busy), .rx_ninth_bit_o(nine), .receive_interrupt_o(irq),
    .dev_txd(u_ufm_link_if.dev_txd));
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  // counted at negedge so registered pulses are read settled
  always @(negedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (irq === 1'b1) irq_n <= irq_n + 1;
    if (irq2 === 1'b1) irq2_n <= irq2_n + 1;
    if (rv === 1'b1) rv_n <= rv_n + 1;
    if (cyc == 20000) begin
      err_count++;
      finish_test();
    end
  end
  task automatic check(input string what, input logic [11:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  function automatic logic [11:0] frame(input int nd, input logic [7:0] d,
                                        input logic hx, xb, input int ns);
    logic [11:0] f;
    int          k;
    f = '0;
    for (k = 0; k < nd; k++) f[k+1] = d[k];
    k = nd + 1;
    if (hx) f[k] = xb;
    k = k + int'(hx);
    for (int s = 0; s < ns; s++) f[k+s] = 1'b1;
    return f;
  endfunction
  task automatic send_tx(input logic [7:0] d, input logic n9);
    @(negedge sys_clk_i);
    tx9 = n9;
    @(negedge sys_clk_i);
    wr = 1'b1;
    txb = d;
    @(negedge sys_clk_i);
    wr = 1'b0;
  endtask
  task automatic peer_send(input logic a, input logic [7:0] b);
    @(negedge sys_clk_i);
    s_addr = a;
    s_data = ~a;
    pbyte = b;
    @(negedge sys_clk_i);
    s_addr = 1'b0;
    s_data = 1'b0;
  endtask
  // samples mid-bit; a missed start samples the idle line, so bit 0 reads one and it fails
  task automatic grab(input int n, output logic [11:0] f);
    int w;
    f = '1;
    w = 0;
    while (u_ufm_link_if.dev_txd !== 1'b0 && w < 40) begin
      @(negedge sys_clk_i);
      w++;
    end
    repeat (B / 2) @(negedge sys_clk_i);
    for (int i = 0; i < 12; i++) begin
      if (i < n) f[i] = u_ufm_link_if.dev_txd;
      else f[i] = 1'b0;
      if (i < n) repeat (B) @(negedge sys_clk_i);
    end
  endtask
  task automatic settle();
    int w;
    w = 0;
    do begin
      @(negedge sys_clk_i);
      w++;
    end while ((busy !== 1'b0 || pbusy !== 1'b0) && w < 300);
    repeat (2 * B) @(negedge sys_clk_i);
  endtask
  task automatic bang(input logic [11:0] f, input int n);
    for (int i = 0; i < n; i++) begin
      u_ufm_link_if_2.peer_txd = f[i];
      repeat (B) @(negedge sys_clk_i);
    end
    u_ufm_link_if_2.peer_txd = 1'b1;
    repeat (2 * B) @(negedge sys_clk_i);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // table: mode, parity on, even, two stops, ninth bit, data
  task automatic t_formats();
    logic [13:0] tab [6] = '{14'h10b5, 14'h1c13, 14'h2a96, 14'h33a5, 14'h305a, 14'h2001};
    logic [11:0] f;
    logic [7:0]  dd;
    logic        m9, hx, xb;
    int          nd;
    foreach (tab[i]) begin
      {mode, pe, even, stop2} = tab[i][13:9];
      m9 = (mode == ufm_pkg::MODE_9BIT);
      nd = (mode == ufm_pkg::MODE_7BIT) ? 7 : 8;
      dd = (nd == 7) ? {1'b0, tab[i][6:0]} : tab[i][7:0];
      hx = m9 | pe;
      xb = m9 ? tab[i][8] : (^dd) ^ ~even;
      send_tx(tab[i][7:0], tab[i][8]);
      // a second write lands during the start bit and must be dropped
      fork
        grab(2 + nd + int'(hx) + int'(stop2), f);
        send_tx(~tab[i][7:0], ~tab[i][8]);
      join
      check("frame", f, frame(nd, dd, hx, xb, 1 + int'(stop2)));
      settle();
    end
    $display("t_formats done");
  endtask
  task automatic t_refused();
    mode = ufm_pkg::MODE_SYNC;
    send_tx(8'h55, 1'b0);
    repeat (3) @(negedge sys_clk_i);
    check("idle", {10'h0, busy, u_ufm_link_if.dev_txd}, 12'h001);
    $display("t_refused done");
  endtask
  task automatic t_wake();
    int n0;
    {mode, pe, stop2, wake} = {ufm_pkg::MODE_9BIT, 3'b001};
    n0 = irq_n;
    peer_send(1'b1, 8'h5c);
    settle();
    check("addr irq", 12'(irq_n - n0), 12'h001);
    check("addr", {3'h0, nine, rx_data}, 12'h15c);
    peer_send(1'b0, 8'h3e);
    settle();
    check("filtered irq", 12'(irq_n - n0), 12'h001);
    check("kept", {3'h0, nine, rx_data}, 12'h15c);
    wake = 1'b0;
    peer_send(1'b0, 8'h3e);
    settle();
    check("data irq", 12'(irq_n - n0), 12'h002);
    check("data", {3'h0, nine, rx_data}, 12'h03e);
    mode = ufm_pkg::MODE_8BIT;
    n0 = rv_n;
    send_tx(8'hc7, 1'b0);
    settle();
    check("reply", {3'h0, 1'(rv_n - n0), reply}, 12'h1c7);
    $display("t_wake done");
  endtask
  task automatic t_rx();
    int n0;
    {mode, pe, even, stop2, wake} = {ufm_pkg::MODE_8BIT, 4'b1000};
    n0 = irq2_n;
    bang(frame(8, 8'h96, 1'b1, 1'b0, 1), 11);
    check("parity", {1'(irq2_n - n0), 1'b0, perr2, ferr2, rx2_data}, 12'ha96);
    {mode, pe} = {ufm_pkg::MODE_7BIT, 1'b0};
    bang(frame(7, 8'h2a, 1'b0, 1'b0, 0), 9);
    check("framing", {2'h0, perr2, ferr2, rx2_data}, 12'h12a);
    // parity left on in 9-bit mode: software slip the channel must ride out
    {mode, pe, wake} = {ufm_pkg::MODE_9BIT, 2'b11};
    n0 = irq2_n;
    bang(frame(8, 8'h77, 1'b1, 1'b0, 1), 11);
    check("drop", {1'(irq2_n - n0), 3'h0, rx2_data}, 12'h02a);
    bang(frame(8, 8'h77, 1'b1, 1'b1, 1), 11);
    check("wake", {1'(irq2_n - n0), 2'h0, nine2, rx2_data}, 12'h977);
    $display("t_rx done");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {rst_i, wake, pe, even, stop2, wr, tx9, s_addr, s_data} = 9'h100;
    {mode, txb, pbyte} = {ufm_pkg::MODE_8BIT, 16'h0};
    u_ufm_link_if_2.peer_txd = 1'b1;
    repeat (8) @(negedge sys_clk_i);
    rst_i = 1'b0;
    t_formats();
    t_refused();
    t_wake();
    t_rx();
    finish_test();
  end
endmodule
